// File: bench/tb_word_multiply_negate_or_block_out.sv
// self-checking bench for multiply, negate, or, idle and block output
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_word_multiply_negate_or_block_out
    import wmb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, irq_req;
    logic        mem_req, mem_word, mem_ack, io_req, io_word, io_ack, e_word;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  dly;
    logic [15:0] mem_addr, mem_rdata, io_data, eb_hl, e_dat;
    logic [23:0] io_addr, e_io;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          n_mismatch = 0, num_checks = 0, n_io;
    wmb_exec uut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .irq_req, .mem_req, .mem_addr, .mem_word, .mem_ack, .mem_rdata,
        .io_req, .io_addr, .io_data, .io_word, .io_ack);
    wmb_far_model far (.hclk, .dly, .mem_req, .mem_addr, .mem_ack,
        .mem_rdata, .io_req, .io_ack);
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    assign e_dat = (eb_hl ^ 16'hA5C3) & (e_word ? 16'hFFFF : 16'h00FF);
    always @(posedge hclk) begin
        if (mem_req === 1'b1 && mem_ack === 1'b1)
            `CHK("mem_word", e_word, mem_word)
        if (io_req === 1'b1 && io_ack === 1'b1) begin
            `CHK("io_addr", e_io, io_addr)
            `CHK("io_word", e_word, io_word)
            `CHK("io_data", e_dat, io_data)
            e_io[15:8] = e_io[15:8] - 8'h01;
            eb_hl = eb_hl - (e_word ? 16'h0002 : 16'h0001);
            n_io++;
        end
    end
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge hclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string n);
        bus(a, 1'b0, 32'h0);
        `CHK(n, e, rd)
    endtask
    task automatic run(input logic [23:0] c);
        wr(OFF_CMD, {8'h00, c});
        do bus(OFF_STATUS, 1'b0, 32'h0); while (rd[STS_BUSY] !== 1'b0);
    endtask
    task automatic op(input logic [23:0] c, input logic [15:0] af, hl,
                      input logic [7:0] o, input logic [15:0] v, ea, ed, eh);
        wr(OFF_AF, {16'h0, af});
        wr(OFF_DE, 32'h0);
        wr(OFF_HL, {16'h0, hl});
        wr(o, {16'h0, v});
        run(c);
        rchk(OFF_AF, {16'h0, ea}, "af");
        rchk(OFF_DE, {16'h0, ed}, "de");
        rchk(OFF_HL, {16'h0, eh}, "hl");
    endtask
    task automatic blk(input logic [7:0] o, b, input logic [15:0] hl,
                       input logic tr, ir, input int n, input logic [7:0] st);
        e_io = {8'h17, b, 8'h46};
        e_word = (o == OP_BLK_W);
        eb_hl = hl;
        n_io = 0;
        irq_req <= ir;
        wr(OFF_TRAPC, {31'h0, tr});
        wr(OFF_IOPAGE, 32'h17);
        wr(OFF_BC, {16'h0, b, 8'h46});
        wr(OFF_HL, {16'h0, hl});
        wr(OFF_AF, 32'h0081);
        wr(OFF_PC, 32'h0200);
        run({16'h00ED, o});
        irq_req <= 1'b0;
        `CHK("n_io", n, n_io)
        rchk(OFF_BC, {16'h0, b - n[7:0], 8'h46}, "bc");
        rchk(OFF_HL, {16'h0, hl - 16'(e_word ? 2 * n : n)}, "hl");
        rchk(OFF_AF, (st == 8'h00) ? 32'h00C3 : 32'h0081, "af");
        rchk(OFF_PC, (st == 8'h00) ? 32'h0202 : 32'h0200, "pc");
        rchk(OFF_STATUS, {24'h0, st}, "status");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #600000;
        n_mismatch++;
        end_sim;
    end
    initial begin
        {hresetn, hsel, hwrite, irq_req, e_word} = 5'h00;
        {haddr, hwdata, htrans, dly} = 70'h0;
        ce = 1'b1;
        hsize = 3'h2;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(8'h3C, 32'h0, "unmapped");
        op(24'hEDC3, 16'h00FF, 16'hFFFF, OFF_BC, 16'hFFFF, 16'h003B,
           16'hFFFE, 16'h0001);
        rchk(OFF_BC, 32'h0000FFFF, "src");
        op(24'hEDD3, 16'h00FF, 16'h0031, OFF_DE, 16'h000A, 16'h003A,
           16'h0000, 16'h01EA);
        op(24'hEDE2, 16'h00FF, 16'h8000, OFF_HL, 16'h8000, 16'h003B,
           16'h4000, 16'h0000);
        op(24'hEDF2, 16'h00FF, 16'hFFFF, OFF_SP, 16'h0002, 16'h00BA,
           16'hFFFF, 16'hFFFE);
        op(24'hEDDDE3, 16'h00FF, 16'h0003, OFF_IX, 16'h0005, 16'h003A,
           16'h0000, 16'h000F);
        wr(OFF_IX, 32'h1000);
        e_word = 1'b1;
        op(24'hEDFDC3, 16'h00FF, 16'h0002, OFF_DISP, 16'h0010, 16'h003B,
           16'h0001, 16'h6BA6);
        op(24'hED44, 16'h0100, 16'h0, OFF_SRC, 16'h0, 16'hFF93,
           16'h0, 16'h0);
        op(24'hED44, 16'h0000, 16'h0, OFF_SRC, 16'h0, 16'h0042,
           16'h0, 16'h0);
        op(24'hED44, 16'h8000, 16'h0, OFF_SRC, 16'h0, 16'h8087,
           16'h0, 16'h0);
        op(24'hED4C, 16'h0000, 16'h0121, OFF_SRC, 16'h0, 16'h0093,
           16'h0, 16'hFEDF);
        op(24'hED4C, 16'h0000, 16'h8000, OFF_SRC, 16'h0, 16'h0087,
           16'h0, 16'h8000);
        op(24'h0000B6, 16'h48FF, 16'h0, OFF_SRC, 16'h0018, 16'h5828,
           16'h0, 16'h0);
        op(24'h00DDB4, 16'h00FF, 16'h0, OFF_IX, 16'h8300, 16'h83A8,
           16'h0, 16'h0);
        op(24'h00FDB5, 16'h00FF, 16'h0, OFF_IY, 16'h1203, 16'h032C,
           16'h0, 16'h0);
        wr(OFF_PC, 32'h0100);
        op(24'h0, 16'h12FF, 16'h5555, OFF_SRC, 16'h0, 16'h12FF,
           16'h0, 16'h5555);
        rchk(OFF_PC, 32'h0101, "pc");
        run(24'h00ED00);
        rchk(OFF_STATUS, 32'h08, "ill");
        ce <= 1'b0;
        wr(OFF_PC, 32'h1234);
        ce <= 1'b1;
        rchk(OFF_PC, 32'h0101, "pc_hold");
        blk(OP_BLK_B, 8'h03, 16'h5218, 1'b0, 1'b0, 3, 8'h00);
        dly <= 4'h2;
        blk(OP_BLK_W, 8'h02, 16'h5006, 1'b0, 1'b0, 2, 8'h00);
        dly <= 4'h0;
        blk(OP_BLK_B, 8'h00, 16'h1000, 1'b0, 1'b0, 256, 8'h00);
        blk(OP_BLK_B, 8'h03, 16'h5218, 1'b1, 1'b0, 0, 8'h02);
        blk(OP_BLK_W, 8'h03, 16'h5218, 1'b0, 1'b1, 1, 8'h04);
        end_sim;
    end
endmodule

// File: bench/wmb_far_model.sv
// far-side memory and io responder with settable latency
module wmb_far_model (
    input  wire logic        hclk,
    input  wire logic [3:0]  dly,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    output logic             mem_ack,
    output logic      [15:0] mem_rdata,
    input  wire logic        io_req,
    output logic             io_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wt = 4'h0;
    initial mem_ack = 1'b0;
    initial io_ack = 1'b0;
    initial mem_rdata = 16'h0000;
    // data line inverts every cycle outside a memory ack, io acks included, instead of holding its value
    always @(posedge hclk) begin
        mem_ack <= 1'b0;
        io_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if ((mem_req && !mem_ack) || (io_req && !io_ack)) begin
            wt <= (wt >= dly) ? 4'h0 : wt + 4'h1;
            if (wt >= dly) begin
                mem_ack <= mem_req;
                io_ack <= io_req && !mem_req;
                if (mem_req)
                    mem_rdata <= mem_addr ^ 16'hA5C3;
            end
        end
    end
endmodule

// File: design/wmb_exec.sv
// execution slice: word multiply, negate, or, idle, block output down
//
// Design decisions made here: the address map and the AHB-Lite register port.
module wmb_exec
    import wmb_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        irq_req,
    output logic             mem_req,
    output logic      [15:0] mem_addr,
    output logic             mem_word,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    output logic             io_req,
    output logic      [23:0] io_addr,
    output logic      [15:0] io_data,
    output logic             io_word,
    input  wire logic        io_ack
);
    function automatic logic [15:0] pair_val(input logic [2:0] rr,
            input logic [15:0] bc, input logic [15:0] de,
            input logic [15:0] hl, input logic [15:0] sp);
        case (rr)
            RR_BC:   pair_val = bc;
            RR_DE:   pair_val = de;
            RR_HL:   pair_val = hl;
            default: pair_val = sp;
        endcase
    endfunction

    function automatic logic wsel(input logic wr, input logic [7:0] a,
            input logic [7:0] off);
        wsel = wr && (a == off);
    endfunction

    wmb_state_e  st_r;
    logic [7:0]  a_r, f_r, iopg_r, trapc_r, waddr_r;
    logic [15:0] bc_r, de_r, hl_r, ix_r, iy_r, sp_r, src_r, disp_r, pc_r;
    logic [15:0] maddr_r, iod_r;
    logic [23:0] cmd_r;
    logic [3:0]  sts_r;
    logic        wpend_r;
    logic [31:0] rdata_r;
    logic [7:0]  a_nxt, f_nxt, or_src, or_res, na_res;
    logic [15:0] bc_nxt, de_nxt, hl_nxt, pc_nxt, mul_src, len, nw_res;
    logic [15:0] xidx, pidx;
    logic [31:0] prod;
    logic        mcarry, exec_en, ill;
    logic        bus_wr, idle;
    logic [7:0]  p1, p2, op;
    logic        ed_only, ix_ed, mul, idle_instruction, nega, negw, oro, blk, xform;
    logic        need16, wform, done;

    assign p1 = cmd_r[15:8];
    assign p2 = cmd_r[23:16];
    assign op = cmd_r[7:0];
    assign idle = (st_r == ST_IDLE);
    assign ed_only = (p1 == PFX_ED) && (p2 == PFX_NONE);
    assign ix_ed = (p1 == PFX_DD || p1 == PFX_FD) && (p2 == PFX_ED);
    assign mul = (ed_only || ix_ed) && (op[7:6] == MUL_GRP) && !op[3]
        && (op[2:0] == MUL_U || op[2:0] == MUL_S);
    assign idle_instruction = (p1 == PFX_NONE) && (p2 == PFX_NONE) && (op == OP_IDLE);
    assign nega = ed_only && (op == OP_NEG_A);
    assign negw = ed_only && (op == OP_NEG_HL);
    assign oro = (p2 == PFX_NONE) && (op[7:3] == OR_GRP)
        && ((p1 == PFX_NONE) || ((p1 == PFX_DD || p1 == PFX_FD)
        && (op[2:0] == RX_HI || op[2:0] == RX_LO)));
    assign blk = ed_only && (op == OP_BLK_B || op == OP_BLK_W);
    assign wform = (op == OP_BLK_W);
    assign xform = mul && ix_ed && (p1 == PFX_FD)
        && (op[5:3] == XY_FIRST || op[5:3] == XY_SECOND);
    assign xidx = (op[5:3] == XY_SECOND) ? iy_r : ix_r;
    assign pidx = (p1 == PFX_FD) ? iy_r : ix_r;
    assign need16 = mul && ix_ed && (op[5:3] != RR_HL)
        && !(p1 == PFX_DD && op[5:3] == XY_FIRST);
    assign len = STEP_BYTE + ((p1 != PFX_NONE) ? STEP_BYTE : RST_WORD)
        + ((p2 != PFX_NONE) ? STEP_BYTE : RST_WORD)
        + (need16 ? STEP_WORD : RST_WORD);
    assign done = (bc_r[15:8] == CNT_LAST);

    always_comb begin
        if (ed_only)
            mul_src = pair_val(op[5:3], bc_r, de_r, hl_r, sp_r);
        else if (op[5:3] == RR_HL)
            mul_src = pidx;
        else if (xform)
            mul_src = mem_rdata;
        else
            mul_src = src_r;
    end

    wmb_mul u_mul (
        .multiplicand (hl_r),
        .multiplier   (mul_src),
        .signed_mode  (op[2:0] == MUL_S),
        .product      (prod),
        .carry        (mcarry)
    );

    always_comb begin
        if (p1 != PFX_NONE)
            or_src = (op[2:0] == RX_HI) ? pidx[15:8] : pidx[7:0];
        else begin
            case (op[2:0])
                3'h0:    or_src = bc_r[15:8];
                3'h1:    or_src = bc_r[7:0];
                3'h2:    or_src = de_r[15:8];
                3'h3:    or_src = de_r[7:0];
                3'h4:    or_src = hl_r[15:8];
                3'h5:    or_src = hl_r[7:0];
                3'h6:    or_src = src_r[7:0];
                default: or_src = a_r;
            endcase
        end
    end

    assign or_res = a_r | or_src;
    assign na_res = 8'(RST_BYTE - a_r);
    assign nw_res = 16'(RST_WORD - hl_r);

    always_comb begin
        a_nxt = a_r;
        f_nxt = f_r;
        bc_nxt = bc_r;
        de_nxt = de_r;
        hl_nxt = hl_r;
        pc_nxt = pc_r + len;
        ill = 1'b0;
        if (st_r == ST_WR) begin
            bc_nxt = {8'(bc_r[15:8] - CNT_LAST), bc_r[7:0]};
            hl_nxt = hl_r - (wform ? STEP_WORD : STEP_BYTE);
            if (done) begin
                f_nxt[F_Z] = 1'b1;
                f_nxt[F_N] = 1'b1;
            end else
                pc_nxt = pc_r;
        end else if (idle_instruction) begin
            pc_nxt = pc_r + STEP_BYTE;
        end else if (oro) begin
            a_nxt = or_res;
            f_nxt[F_S] = or_res[7];
            f_nxt[F_Z] = (or_res == RST_BYTE);
            f_nxt[F_H] = 1'b0;
            f_nxt[F_V] = ~^or_res;
            f_nxt[F_N] = 1'b0;
            f_nxt[F_C] = 1'b0;
        end else if (nega) begin
            a_nxt = na_res;
            f_nxt[F_S] = na_res[7];
            f_nxt[F_Z] = (na_res == RST_BYTE);
            f_nxt[F_H] = (a_r[3:0] != 4'h0);
            f_nxt[F_V] = (a_r == BYTE_MIN);
            f_nxt[F_N] = 1'b1;
            f_nxt[F_C] = (a_r != RST_BYTE);
        end else if (negw) begin
            hl_nxt = nw_res;
            f_nxt[F_S] = nw_res[15];
            f_nxt[F_Z] = (nw_res == RST_WORD);
            f_nxt[F_H] = (hl_r[11:0] != 12'h000);
            f_nxt[F_V] = (hl_r == WORD_MIN);
            f_nxt[F_N] = 1'b1;
            f_nxt[F_C] = (hl_r != RST_WORD);
        end else if (mul) begin
            de_nxt = prod[31:16];
            hl_nxt = prod[15:0];
            f_nxt[F_S] = (op[2:0] == MUL_S) && prod[31];
            f_nxt[F_Z] = (prod == {RST_WORD, RST_WORD});
            f_nxt[F_V] = 1'b0;
            f_nxt[F_C] = mcarry;
        end else begin
            ill = 1'b1;
            pc_nxt = pc_r;
        end
    end

    assign exec_en = ((st_r == ST_DEC) && !xform && !blk)
        || ((st_r == ST_FETCH) && mem_ack) || ((st_r == ST_WR) && io_ack);

    // ahb-lite slave, zero wait, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;
    assign bus_wr = wpend_r && idle;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wpend_r <= 1'b0;
            waddr_r <= RST_BYTE;
            rdata_r <= {RST_WORD, RST_WORD};
        end else if (ce) begin
            wpend_r <= hsel && htrans[1] && hready && hwrite;
            waddr_r <= haddr[7:0];
            if (hsel && htrans[1] && hready && !hwrite) begin
                case (haddr[7:0])
                    OFF_AF:     rdata_r <= {RST_WORD, a_r, f_r};
                    OFF_BC:     rdata_r <= {RST_WORD, bc_r};
                    OFF_DE:     rdata_r <= {RST_WORD, de_r};
                    OFF_HL:     rdata_r <= {RST_WORD, hl_r};
                    OFF_IX:     rdata_r <= {RST_WORD, ix_r};
                    OFF_IY:     rdata_r <= {RST_WORD, iy_r};
                    OFF_SP:     rdata_r <= {RST_WORD, sp_r};
                    OFF_SRC:    rdata_r <= {RST_WORD, src_r};
                    OFF_DISP:   rdata_r <= {RST_WORD, disp_r};
                    OFF_IOPAGE: rdata_r <= {RST_WORD, RST_BYTE, iopg_r};
                    OFF_TRAPC:  rdata_r <= {RST_WORD, RST_BYTE, trapc_r};
                    OFF_PC:     rdata_r <= {RST_WORD, pc_r};
                    OFF_CMD:    rdata_r <= {RST_BYTE, cmd_r};
                    OFF_STATUS: rdata_r <= {RST_WORD, RST_BYTE,
                                            4'h0, sts_r[3:1], !idle};
                    default:    rdata_r <= {RST_WORD, RST_WORD};
                endcase
            end
        end
    end

    // architectural registers: software loads while idle, execution updates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_r <= RST_BYTE;
            f_r <= RST_BYTE;
            bc_r <= RST_WORD;
            de_r <= RST_WORD;
            hl_r <= RST_WORD;
            ix_r <= RST_WORD;
            iy_r <= RST_WORD;
            sp_r <= RST_WORD;
            src_r <= RST_WORD;
            disp_r <= RST_WORD;
            iopg_r <= RST_BYTE;
            trapc_r <= RST_BYTE;
            pc_r <= RST_WORD;
        end else if (ce) begin
            if (wsel(bus_wr, waddr_r, OFF_AF)) begin
                a_r <= hwdata[15:8];
                f_r <= hwdata[7:0];
            end
            if (wsel(bus_wr, waddr_r, OFF_BC)) bc_r <= hwdata[15:0];
            if (wsel(bus_wr, waddr_r, OFF_DE)) de_r <= hwdata[15:0];
            if (wsel(bus_wr, waddr_r, OFF_HL)) hl_r <= hwdata[15:0];
            if (wsel(bus_wr, waddr_r, OFF_IX)) ix_r <= hwdata[15:0];
            if (wsel(bus_wr, waddr_r, OFF_IY)) iy_r <= hwdata[15:0];
            if (wsel(bus_wr, waddr_r, OFF_SP)) sp_r <= hwdata[15:0];
            if (wsel(bus_wr, waddr_r, OFF_SRC)) src_r <= hwdata[15:0];
            if (wsel(bus_wr, waddr_r, OFF_DISP)) disp_r <= hwdata[15:0];
            if (wsel(bus_wr, waddr_r, OFF_IOPAGE)) iopg_r <= hwdata[7:0];
            if (wsel(bus_wr, waddr_r, OFF_TRAPC)) trapc_r <= hwdata[7:0];
            if (wsel(bus_wr, waddr_r, OFF_PC)) pc_r <= hwdata[15:0];
            if (exec_en) begin
                a_r <= a_nxt;
                f_r <= f_nxt;
                bc_r <= bc_nxt;
                de_r <= de_nxt;
                hl_r <= hl_nxt;
                pc_r <= pc_nxt;
            end
        end
    end

    // sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= ST_IDLE;
            cmd_r <= {RST_BYTE, RST_WORD};
            sts_r <= 4'h0;
            maddr_r <= RST_WORD;
            iod_r <= RST_WORD;
        end else if (ce) begin
            case (st_r)
                ST_IDLE: begin
                    if (wsel(bus_wr, waddr_r, OFF_CMD)) begin
                        cmd_r <= hwdata[23:0];
                        sts_r <= 4'h0;
                        st_r <= ST_DEC;
                    end
                end
                ST_DEC: begin
                    if (xform) begin
                        maddr_r <= xidx + disp_r;
                        st_r <= ST_FETCH;
                    end else if (blk && trapc_r[TRAP_INH]) begin
                        sts_r[STS_TRAP] <= 1'b1;
                        st_r <= ST_IDLE;
                    end else if (blk) begin
                        maddr_r <= hl_r;
                        st_r <= ST_RD;
                    end else begin
                        sts_r[STS_ILL] <= ill;
                        st_r <= ST_IDLE;
                    end
                end
                ST_FETCH: begin
                    if (mem_ack)
                        st_r <= ST_IDLE;
                end
                ST_RD: begin
                    if (mem_ack) begin
                        iod_r <= wform ? mem_rdata : {RST_BYTE, mem_rdata[7:0]};
                        st_r <= ST_WR;
                    end
                end
                ST_WR: begin
                    if (io_ack) begin
                        maddr_r <= hl_nxt;
                        if (done)
                            st_r <= ST_IDLE;
                        else if (irq_req) begin
                            sts_r[STS_IRQ] <= 1'b1;
                            st_r <= ST_IDLE;
                        end else
                            st_r <= ST_RD;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    assign mem_req = (st_r == ST_FETCH) || (st_r == ST_RD);
    assign mem_addr = maddr_r;
    assign mem_word = (st_r == ST_FETCH) || wform;
    assign io_req = (st_r == ST_WR);
    assign io_addr = {iopg_r, bc_r};
    assign io_data = iod_r;
    assign io_word = wform;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic fire;
    assign fire = ce && exec_en;

    mul_u_carry_a: assert property (fire && mul && op[2:0] == MUL_U
        |=> f_r[F_C] == (de_r != RST_WORD))
        else $error("unsigned multiply carry wrong");
    mul_u_flags_a: assert property (fire && mul && op[2:0] == MUL_U
        |=> !f_r[F_S] && !f_r[F_V] && f_r[F_H] == $past(f_r[F_H]))
        else $error("unsigned multiply flags wrong");
    mul_s_carry_a: assert property (fire && mul && op[2:0] == MUL_S
        |=> f_r[F_C] == (de_r != {16{hl_r[15]}}))
        else $error("signed multiply carry wrong");
    mul_s_sign_a: assert property (fire && mul && op[2:0] == MUL_S
        |=> f_r[F_S] == de_r[15] && !f_r[F_V])
        else $error("signed multiply sign wrong");
    neg_byte_a: assert property (fire && nega
        |=> a_r == 8'(RST_BYTE - $past(a_r))
            && f_r[F_C] == ($past(a_r) != RST_BYTE) && f_r[F_N])
        else $error("byte negate wrong");
    neg_word_a: assert property (fire && negw
        |=> f_r[F_V] == ($past(hl_r) == WORD_MIN))
        else $error("word negate overflow wrong");
    or_flags_a: assert property (fire && oro
        |=> !f_r[F_H] && !f_r[F_N] && !f_r[F_C] && f_r[F_V] == ~^a_r)
        else $error("or flags wrong");
    idle_op_a: assert property (fire && idle_instruction && st_r == ST_DEC
        |=> pc_r == 16'($past(pc_r) + STEP_BYTE) && a_r == $past(a_r)
            && hl_r == $past(hl_r))
        else $error("idle instruction changed state");
    blk_count_a: assert property (fire && st_r == ST_WR
        |=> bc_r[15:8] == 8'($past(bc_r[15:8]) - CNT_LAST))
        else $error("block count not decremented");
    blk_trap_a: assert property (ce && st_r == ST_DEC && blk
        && trapc_r[TRAP_INH] |=> idle && sts_r[STS_TRAP] && !io_req)
        else $error("inhibited block output not trapped");

    blk_done_c: cover property (fire && st_r == ST_WR && done);
    blk_irq_c: cover property (ce && st_r == ST_WR && io_ack && !done
        && irq_req);
    mul_x_c: cover property (fire && st_r == ST_FETCH);
    neg_min_c: cover property (fire && negw && hl_r == WORD_MIN);
endmodule

// File: design/wmb_mul.sv
// 16 x 16 multiplier, signed or unsigned, with range carry
module wmb_mul
    import wmb_pkg::*;
(
    input  wire logic [15:0] multiplicand,
    input  wire logic [15:0] multiplier,
    input  wire logic        signed_mode,
    output logic      [31:0] product,
    output logic             carry
);
    logic [16:0] ea;
    logic [16:0] eb;
    logic [33:0] full;

    assign ea = {signed_mode & multiplicand[15], multiplicand};
    assign eb = {signed_mode & multiplier[15], multiplier};
    assign full = 34'($signed(ea) * $signed(eb));
    assign product = full[31:0];
    assign carry = signed_mode ? (product[31:16] != {16{product[15]}})
                               : (product[31:16] != RST_WORD);
endmodule

// File: design/wmb_pkg.sv
// constants, offsets and state type for the word multiply / negate / block out
// Summary of operation
// - unsigned multiply: pointer_pair times source, product high to upper pair
// - unsigned multiply sets carry when product reaches 2**16, else upper zero
// - unsigned multiply clears sign and overflow, zero on zero product
// - signed multiply forms 32-bit two's-complement product in both pairs
// - signed multiply carry set when product leaves 16-bit signed range
// - signed multiply: sign and zero from product, overflow cleared
// - register form pair field 000/010/100/110, low bits 011 or 010
// - indexed form: 000 first index, 010 second, 16-bit displacement low first
// - byte negate: accumulator two's complement, half-carry borrow bit 4, subtract
// - byte negate carry set when accumulator was nonzero
// - negate opcodes after prefix: 01 000 100 byte, 01 001 100 word
// - word negate: 8000 maps to itself and sets overflow
// - word negate: half-carry borrow bit 12, carry if nonzero, subtract set
// - inclusive or of accumulator and source into accumulator
// - or flags: sign, zero, even parity, clear half-carry, subtract, carry
// - index byte field 100 high, 101 low; prefix bit picks index register
// - block output repeats, decrements count, zero start gives 256 transfers
// - pointer pair drops by one per byte, two per word
// - io address: port low byte, count bits 8-15, io page bits 16-23
// - interruptible between transfers, start pc kept, completion sets zero, subtract
// - block output traps when inhibit user io bit is one
// - block output opcodes 10 111 011 byte, 10 011 011 word
package wmb_pkg;
    localparam logic [7:0]  OFF_AF      = 8'h00;
    localparam logic [7:0]  OFF_BC      = 8'h04;
    localparam logic [7:0]  OFF_DE      = 8'h08;
    localparam logic [7:0]  OFF_HL      = 8'h0C;
    localparam logic [7:0]  OFF_IX      = 8'h10;
    localparam logic [7:0]  OFF_IY      = 8'h14;
    localparam logic [7:0]  OFF_SP      = 8'h18;
    localparam logic [7:0]  OFF_SRC     = 8'h1C;
    localparam logic [7:0]  OFF_DISP    = 8'h20;
    localparam logic [7:0]  OFF_IOPAGE  = 8'h24;
    localparam logic [7:0]  OFF_TRAPC   = 8'h28;
    localparam logic [7:0]  OFF_PC      = 8'h2C;
    localparam logic [7:0]  OFF_CMD     = 8'h30;
    localparam logic [7:0]  OFF_STATUS  = 8'h34;
    localparam int          F_S         = 7;
    localparam int          F_Z         = 6;
    localparam int          F_H         = 4;
    localparam int          F_V         = 2;
    localparam int          F_N         = 1;
    localparam int          F_C         = 0;
    localparam int          TRAP_INH    = 0;
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_WORD    = 16'h0000;
    localparam logic [7:0]  PFX_NONE    = 8'h00;
    localparam logic [7:0]  PFX_ED      = 8'hED;
    localparam logic [7:0]  PFX_DD      = 8'hDD;
    localparam logic [7:0]  PFX_FD      = 8'hFD;
    localparam logic [7:0]  OP_IDLE     = 8'h00;
    localparam logic [7:0]  OP_NEG_A    = 8'h44;
    localparam logic [7:0]  OP_NEG_HL   = 8'h4C;
    localparam logic [7:0]  OP_BLK_B    = 8'hBB;
    localparam logic [7:0]  OP_BLK_W    = 8'h9B;
    localparam logic [2:0]  MUL_U       = 3'h3;
    localparam logic [2:0]  MUL_S       = 3'h2;
    localparam logic [1:0]  MUL_GRP     = 2'h3;
    localparam logic [4:0]  OR_GRP      = 5'h16;
    localparam logic [2:0]  RR_BC       = 3'h0;
    localparam logic [2:0]  RR_DE       = 3'h2;
    localparam logic [2:0]  RR_HL       = 3'h4;
    localparam logic [2:0]  RR_SP       = 3'h6;
    localparam logic [2:0]  XY_FIRST    = 3'h0;
    localparam logic [2:0]  XY_SECOND   = 3'h2;
    localparam logic [2:0]  RX_HI       = 3'h4;
    localparam logic [2:0]  RX_LO       = 3'h5;
    localparam logic [7:0]  BYTE_MIN    = 8'h80;
    localparam logic [15:0] WORD_MIN    = 16'h8000;
    localparam logic [15:0] STEP_BYTE   = 16'h0001;
    localparam logic [15:0] STEP_WORD   = 16'h0002;
    localparam logic [7:0]  CNT_LAST    = 8'h01;
    localparam int          STS_BUSY    = 0;
    localparam int          STS_TRAP    = 1;
    localparam int          STS_IRQ     = 2;
    localparam int          STS_ILL     = 3;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEC,
        ST_FETCH,
        ST_RD,
        ST_WR
    } wmb_state_e;
endpackage
